// >>> design/spec_consts.svh
// offsets, reset values and field positions of the system protect / eeprom register bank
//
// Functional notes
// R1 - protected bits writable only after key unlock
// R2 - 16-bit key register, reset zero, readable
// R3 - protected writes silently dropped while locked
// R4 - unlock persists until another key stored
// R5 - 3-bit ram size, reset 2KB
// R6 - 2-bit flash wait, reset one
// R7 - software sets flash wait before clock change
// R8 - eeprom reset bit resets to one
// R9 - eeprom reset low disables all functions
// R10 - software resets eeprom on missing completion
// R11 - supply on only while reprogram mode
// R12 - reprogram mode bit, reset zero
// R13 - strobe write gives one pulse, reads zero
// R14 - 8-bit program address, reset zero
// R15 - 8-bit program data, reset zero
// R16 - ecc and completion flags, write one clears
// R17 - request while flag and enable both one
// R18 - software clears flag before enabling
// R19 - enabling with flag set raises request
// R20 - macro events set the flags
// R21 - reserved bits read constants, ignore writes; bit 8 of the ram size register is stored and read back
`ifndef SPEC_CONSTS_SVH
`define SPEC_CONSTS_SVH

`define SPEC_OFS_KEY      4'h0
`define SPEC_OFS_RAMSZ    4'h1
`define SPEC_OFS_FWAIT    4'h2
`define SPEC_OFS_CTL0     4'h3
`define SPEC_OFS_CTL1     4'h4
`define SPEC_OFS_ADDR     4'h5
`define SPEC_OFS_WDAT     4'h6
`define SPEC_OFS_INTF     4'h7
`define SPEC_OFS_INTE     4'h8

`define SPEC_UNLOCK_KEY   16'h0096
`define SPEC_RST_KEY      16'h0000
`define SPEC_RST_RAMSZ    3'h2
`define SPEC_RST_FWAIT    2'h1
`define SPEC_RAMSZ_FIXED  16'h0020
`define SPEC_POS_XPOR     8
`define SPEC_POS_PWR      1
`define SPEC_POS_WMODE    0
`define SPEC_POS_ECC      1
`define SPEC_POS_DONE     0

`endif

// >>> design/spec_pkg.sv
// types of the system protect / eeprom register bank
package spec_pkg;
	typedef struct packed {
		logic       ecc;
		logic       done;
	} spec_irq_t;

	typedef struct packed {
		logic       reset_n;
		logic       reprogram_mode;
		logic       supply_on;
		logic       pulse;
		logic [7:0] address;
		logic [7:0] data;
	} spec_eep_t;
endpackage

// >>> design/spec_regbank.sv
// system protect key, ram size, flash wait and eeprom controller registers
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`include "spec_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spec_regbank (
	// clock and reset
	input  wire logic                CLK_I,
	input  wire logic                RESETN_I,
	input  wire logic                CE_I,
	// avalon-mm slave
	input  wire logic [5:0]          AVS_ADDRESS_I,
	input  wire logic                AVS_READ_I,
	input  wire logic                AVS_WRITE_I,
	input  wire logic [31:0]         AVS_WRITEDATA_I,
	input  wire logic [3:0]          AVS_BYTEENABLE_I,
	output logic      [31:0]         AVS_READDATA_O,
	output logic                     AVS_WAITREQUEST_O,
	output logic      [1:0]          AVS_RESPONSE_O,
	// eeprom macro
	output spec_pkg::spec_eep_t      EEP_O,
	input  wire logic                EEP_DONE_I,
	input  wire logic                EEP_ECC_I,
	// system settings and request
	output logic      [2:0]          RAM_SIZE_SELECT_O,
	output logic      [1:0]          FLASH_WAIT_CYCLES_O,
	output logic                     IRQ_O
);

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0]         protect_key_value;
	logic [2:0]          ram_size_select;
	logic                ram_bit8;
	logic [1:0]          flash_wait_cycles;
	logic                eeprom_reset_release;
	logic                program_supply_on;
	logic                reprogram_mode;
	logic                program_pulse;
	logic [7:0]          program_byte_address;
	logic [7:0]          program_byte_data;
	spec_pkg::spec_irq_t flags;
	spec_pkg::spec_irq_t enables;
	logic                ack;
	logic [31:0]         rdata;
	logic [1:0]          resp;
	logic [1:0]          done_sync;
	logic [1:0]          ecc_sync;
	logic                done_prev;
	logic                ecc_prev;

	// one wait cycle, so the answer comes from flops and the master always sees it settle
	// a write lands only at the edge where the master sees waitrequest low
	wire       req       = (AVS_READ_I | AVS_WRITE_I) & ~ack;
	wire       wr        = AVS_WRITE_I & ack & CE_I;
	wire [3:0] idx       = AVS_ADDRESS_I[5:2];
	wire       in_range  = (AVS_ADDRESS_I[1:0] == 2'h0) && (idx <= `SPEC_OFS_INTE);
	wire       lo_be     = AVS_BYTEENABLE_I[0];
	wire       hi_be     = AVS_BYTEENABLE_I[1];
	wire       unlocked  = (protect_key_value == `SPEC_UNLOCK_KEY); // [R1] [R2] [R4]
	wire       pwr       = unlocked & wr & lo_be & in_range;        // [R3]
	wire [15:0] wd       = AVS_WRITEDATA_I[15:0];
	wire       wr_key    = wr & in_range & (idx == `SPEC_OFS_KEY);
	wire       wr_ramsz  = pwr & (idx == `SPEC_OFS_RAMSZ);
	wire       wr_fwait  = pwr & (idx == `SPEC_OFS_FWAIT);
	wire       wr_ctl0   = pwr & (idx == `SPEC_OFS_CTL0);
	wire       wr_ctl0_h = unlocked & wr & hi_be & in_range & (idx == `SPEC_OFS_CTL0);
	wire       wr_ctl1   = pwr & (idx == `SPEC_OFS_CTL1);
	wire       wr_addr   = pwr & (idx == `SPEC_OFS_ADDR);
	wire       wr_wdat   = pwr & (idx == `SPEC_OFS_WDAT);
	wire       wr_intf   = pwr & (idx == `SPEC_OFS_INTF);
	wire       wr_inte   = pwr & (idx == `SPEC_OFS_INTE);
	wire       done_rise = done_sync[1] & ~done_prev;
	wire       ecc_rise  = ecc_sync[1] & ~ecc_prev;
	wire       set_done  = done_rise & eeprom_reset_release;        // [R9] [R20]
	wire       set_ecc   = ecc_rise & eeprom_reset_release;         // [R9] [R20]
	wire       clr_done  = wr_intf & wd[`SPEC_POS_DONE];
	wire       clr_ecc   = wr_intf & wd[`SPEC_POS_ECC];
	// strobe only fires in reprogram mode with the macro out of reset
	wire       fire      = wr_ctl1 & wd[0] & reprogram_mode & eeprom_reset_release; // [R13]
	wire [15:0] next_ctl0_rd = {7'h00, eeprom_reset_release, 6'h00,
				program_supply_on, reprogram_mode};

	////////////////////////////////////////////////////////////////////////////////
	// read mux: reserved bits constant, bit 8 of the ram size register kept as stored
	logic [15:0] rd_word;
	always_comb begin
		case (idx)
			`SPEC_OFS_KEY:   rd_word = protect_key_value;                              // [R2]
			`SPEC_OFS_RAMSZ: rd_word = `SPEC_RAMSZ_FIXED | {7'h00, ram_bit8, 5'h00,
						ram_size_select};                                  // [R21]
			`SPEC_OFS_FWAIT: rd_word = {14'h0000, flash_wait_cycles};
			`SPEC_OFS_CTL0:  rd_word = next_ctl0_rd;
			`SPEC_OFS_CTL1:  rd_word = 16'h0000;                                       // [R13]
			`SPEC_OFS_ADDR:  rd_word = {8'h00, program_byte_address};
			`SPEC_OFS_WDAT:  rd_word = {8'h00, program_byte_data};
			`SPEC_OFS_INTF:  rd_word = {14'h0000, flags.ecc, flags.done};
			`SPEC_OFS_INTE:  rd_word = {14'h0000, enables.ecc, enables.done};
			default:         rd_word = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ack   <= 1'b0;
			rdata <= 32'h0000_0000;
			resp  <= 2'h0;
		end else if (CE_I) begin
			ack   <= req;
			rdata <= (AVS_READ_I & in_range) ? {16'h0000, rd_word} : 32'h0000_0000;
			resp  <= in_range ? 2'h0 : 2'h3;
		end
	end

	// key register takes any write; protection follows from its value
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			protect_key_value <= `SPEC_RST_KEY;  // [R2]
		end else if (wr_key) begin
			if (lo_be) begin
				protect_key_value[7:0] <= wd[7:0];
			end
			if (hi_be) begin
				protect_key_value[15:8] <= wd[15:8];
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ram_size_select   <= `SPEC_RST_RAMSZ; // [R5]
			ram_bit8          <= 1'b0;
			flash_wait_cycles <= `SPEC_RST_FWAIT; // [R6]
		end else begin
			if (wr_ramsz) begin
				ram_size_select <= wd[2:0];      // [R5]
			end
			if (unlocked & wr & hi_be & in_range & (idx == `SPEC_OFS_RAMSZ)) begin
				ram_bit8 <= wd[8];
			end
			if (wr_fwait) begin
				flash_wait_cycles <= wd[1:0];    // [R6]
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			eeprom_reset_release <= 1'b1;  // [R8]
			program_supply_on    <= 1'b0;
			reprogram_mode       <= 1'b0;  // [R12]
			program_byte_address <= 8'h00; // [R14]
			program_byte_data    <= 8'h00; // [R15]
			program_pulse        <= 1'b0;
		end else if (CE_I) begin
			program_pulse <= fire;         // [R13]
			if (wr_ctl0_h) begin
				eeprom_reset_release <= wd[`SPEC_POS_XPOR]; // [R8]
			end
			if (wr_ctl0) begin
				program_supply_on <= wd[`SPEC_POS_PWR];
				reprogram_mode    <= wd[`SPEC_POS_WMODE];    // [R12]
			end
			if (wr_addr) begin
				program_byte_address <= wd[7:0];            // [R14]
			end
			if (wr_wdat) begin
				program_byte_data <= wd[7:0];               // [R15]
			end
		end
	end

	// event inputs come from the macro, so they are synchronised first
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			done_sync <= 2'h0;
			ecc_sync  <= 2'h0;
			done_prev <= 1'b0;
			ecc_prev  <= 1'b0;
		end else if (CE_I) begin
			done_sync <= {done_sync[0], EEP_DONE_I};
			ecc_sync  <= {ecc_sync[0], EEP_ECC_I};
			done_prev <= done_sync[1];
			ecc_prev  <= ecc_sync[1];
		end
	end

	// set wins over a simultaneous write-one clear
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			flags   <= '0;
			enables <= '0; // [R17]
		end else if (CE_I) begin
			flags.done <= set_done | (flags.done & ~clr_done); // [R16]
			flags.ecc  <= set_ecc | (flags.ecc & ~clr_ecc);    // [R16]
			if (wr_inte) begin
				enables.done <= wd[`SPEC_POS_DONE];
				enables.ecc  <= wd[`SPEC_POS_ECC];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// macro side: mode and supply forced off while the macro is held in reset; address and data pass through
	assign EEP_O.reset_n        = eeprom_reset_release;                         // [R8]
	assign EEP_O.reprogram_mode = reprogram_mode & eeprom_reset_release;        // [R9] [R12]
	assign EEP_O.supply_on      = program_supply_on & reprogram_mode
				& eeprom_reset_release;                              // [R11]
	assign EEP_O.pulse          = program_pulse;                                // [R13]
	assign EEP_O.address        = program_byte_address;                         // [R14]
	assign EEP_O.data           = program_byte_data;                            // [R15]
	assign RAM_SIZE_SELECT_O    = ram_size_select;
	assign FLASH_WAIT_CYCLES_O  = flash_wait_cycles;
	// level request: turning an enable on over a set flag raises it at once
	assign IRQ_O = (flags.done & enables.done) | (flags.ecc & enables.ecc); // [R17] [R19]
	assign AVS_READDATA_O    = rdata;
	assign AVS_WAITREQUEST_O = ~ack;
	assign AVS_RESPONSE_O    = resp;

	////////////////////////////////////////////////////////////////////////////////
	property p_locked_ramsz;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!unlocked && wr) |=> $stable(ram_size_select) && $stable(program_byte_data);
	endproperty
	a_locked_ramsz: assert property (p_locked_ramsz) else $error("locked write changed"); // [R3]

	property p_unlock_write;
		@(posedge CLK_I) disable iff (!RESETN_I)
		wr_addr |=> program_byte_address == $past(wd[7:0]);
	endproperty
	a_unlock_write: assert property (p_unlock_write) else $error("unlocked write lost"); // [R1]

	property p_pulse_one;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(EEP_O.pulse && CE_I) |=> !EEP_O.pulse;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one"); // [R13]

	property p_pulse_mode;
		@(posedge CLK_I) disable iff (!RESETN_I)
		EEP_O.pulse |-> $past(reprogram_mode) && $past(unlocked);
	endproperty
	a_pulse_mode: assert property (p_pulse_mode) else $error("pulse outside mode"); // [R13]

	property p_supply;
		@(posedge CLK_I) disable iff (!RESETN_I)
		EEP_O.supply_on |-> reprogram_mode && eeprom_reset_release;
	endproperty
	a_supply: assert property (p_supply) else $error("supply without mode"); // [R11]

	property p_irq;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(flags.done && enables.done) |-> IRQ_O;
	endproperty
	a_irq: assert property (p_irq) else $error("request missing"); // [R17]

	property p_set_wins;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(set_done && CE_I) |=> flags.done;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("completion event lost"); // [R16]

	property p_clear;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(clr_ecc && !set_ecc && CE_I) |=> !flags.ecc;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared"); // [R16]

	property p_reset_off;
		@(posedge CLK_I) disable iff (!RESETN_I)
		!eeprom_reset_release |-> !EEP_O.reprogram_mode && !EEP_O.supply_on;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("active in reset"); // [R9]

	property p_key_rel;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(wr_key && lo_be && hi_be && wd != `SPEC_UNLOCK_KEY) |=> !unlocked;
	endproperty
	a_key_rel: assert property (p_key_rel) else $error("relock failed"); // [R4]

	property p_key_store;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(wr_key && lo_be && hi_be) |=> protect_key_value == $past(wd);
	endproperty
	a_key_store: assert property (p_key_store) else $error("key not stored"); // [R2]

	property p_key_hold;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(unlocked && !wr_key) |=> unlocked;
	endproperty
	a_key_hold: assert property (p_key_hold) else $error("unlock lost"); // [R4]

	property p_locked_ctl;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!unlocked && wr) |=> $stable(reprogram_mode) && $stable(program_supply_on)
			&& $stable(eeprom_reset_release);
	endproperty
	a_locked_ctl: assert property (p_locked_ctl) else $error("locked control changed"); // [R3]

	property p_locked_misc;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!unlocked && wr) |=> $stable(flash_wait_cycles) && $stable(program_byte_address)
			&& $stable(enables);
	endproperty
	a_locked_misc: assert property (p_locked_misc) else $error("locked field changed"); // [R3]

	property p_locked_flags;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!unlocked && wr && !set_done && !set_ecc) |=> $stable(flags);
	endproperty
	a_locked_flags: assert property (p_locked_flags) else $error("locked flag changed"); // [R3]

	property p_ramsz_write;
		@(posedge CLK_I) disable iff (!RESETN_I)
		wr_ramsz |=> ram_size_select == $past(wd[2:0]);
	endproperty
	a_ramsz_write: assert property (p_ramsz_write) else $error("ram size lost"); // [R5]

	property p_fwait_write;
		@(posedge CLK_I) disable iff (!RESETN_I)
		wr_fwait |=> flash_wait_cycles == $past(wd[1:0]);
	endproperty
	a_fwait_write: assert property (p_fwait_write) else $error("flash wait lost"); // [R6]

	property p_data_write;
		@(posedge CLK_I) disable iff (!RESETN_I)
		wr_wdat |=> program_byte_data == $past(wd[7:0]);
	endproperty
	a_data_write: assert property (p_data_write) else $error("program data lost"); // [R15]

	property p_pulse_fire;
		@(posedge CLK_I) disable iff (!RESETN_I)
		fire |=> EEP_O.pulse;
	endproperty
	a_pulse_fire: assert property (p_pulse_fire) else $error("strobe gave no pulse"); // [R13]

	property p_strobe_read;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!AVS_WAITREQUEST_O && AVS_READ_I && in_range && idx == `SPEC_OFS_CTL1)
			|-> AVS_READDATA_O == 32'h0000_0000;
	endproperty
	a_strobe_read: assert property (p_strobe_read) else $error("strobe read not zero"); // [R13]

	property p_irq_ecc;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(flags.ecc && enables.ecc) |-> IRQ_O;
	endproperty
	a_irq_ecc: assert property (p_irq_ecc) else $error("ecc request missing"); // [R17]

	property p_irq_enable;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(wr_inte && wd[`SPEC_POS_DONE] && flags.done) |=> IRQ_O;
	endproperty
	a_irq_enable: assert property (p_irq_enable) else $error("enable over flag silent"); // [R19]

	property p_ecc_set;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(set_ecc && CE_I) |=> flags.ecc;
	endproperty
	a_ecc_set: assert property (p_ecc_set) else $error("ecc event lost"); // [R20]

	property p_events_off;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!eeprom_reset_release && !flags.done && CE_I) |=> !flags.done;
	endproperty
	a_events_off: assert property (p_events_off) else $error("event taken in reset"); // [R9]

	property p_reset_pulse;
		@(posedge CLK_I) disable iff (!RESETN_I)
		!eeprom_reset_release |=> !EEP_O.pulse;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("pulse in reset"); // [R9]

	property p_write_zero;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(wr_intf && !wd[`SPEC_POS_DONE] && flags.done) |=> flags.done;
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("zero write cleared"); // [R16]

	property p_unmapped;
		@(posedge CLK_I) disable iff (!RESETN_I)
		(!AVS_WAITREQUEST_O && !in_range) |-> AVS_RESPONSE_O == 2'h3
			&& AVS_READDATA_O == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped answer wrong"); // [R21]
endmodule
`default_nettype wire

// >>> dv/spec_eep_model.sv
// behavioural model of the eeprom macro at the far side of the register bank
`timescale 1ns/1ps
`default_nettype none
module spec_eep_model #(
	parameter int LAT = 4
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire spec_pkg::spec_eep_t eep_i,
	input  wire logic                ecc_req_i,
	output logic                     done_o,
	output logic                     ecc_o
);
	int cnt;
	// done stands two cycles so the synchroniser in the bank cannot miss it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			done_o <= 1'b0;
			ecc_o <= 1'b0;
		end else begin
			ecc_o <= ecc_req_i;
			if (eep_i.pulse && eep_i.reprogram_mode && eep_i.reset_n)
				cnt <= LAT;
			else if (cnt != 0)
				cnt <= cnt - 1;
			done_o <= (cnt == 1) || (cnt == 2);
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the protect and eeprom register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                clk, rst_n, rd, wr, ecc_req, wreq, done, ecc, irq, ce;
	logic      [3:0]     be;
	logic      [5:0]     adr;
	logic      [31:0]    wd, rdat, q;
	logic      [1:0]     rsp, rs, fw;
	logic      [2:0]     ram;
	logic      [7:0]     p_adr, p_dat;
	spec_pkg::spec_eep_t eep;
	int                  err_total, total_checks, cyc, pulses;

	spec_regbank i_spec_regbank (.CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
		.AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
		.AVS_RESPONSE_O(rsp), .EEP_O(eep), .EEP_DONE_I(done), .EEP_ECC_I(ecc),
		.RAM_SIZE_SELECT_O(ram), .FLASH_WAIT_CYCLES_O(fw), .IRQ_O(irq));
	spec_eep_model i_spec_eep_model (.clk_i(clk), .rst_n_i(rst_n), .eep_i(eep),
		.ecc_req_i(ecc_req), .done_o(done), .ecc_o(ecc));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// pulses are counted at the edge so a one-cycle strobe is never missed
	always @(posedge clk) begin
		cyc++;
		if (eep.pulse === 1'b1) begin
			pulses++;
			p_adr = eep.address;
			p_dat = eep.data;
		end
		if (cyc == 4000) begin
			err_total++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// request held until waitrequest is sampled low, then released
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		// no local limit: a hang runs into the bench timeout
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat;
		rs = rsp;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrt(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask
	task automatic pulse_chk(input string n, input int e);
		repeat (3) @(posedge clk);
		chk(n, e, pulses);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc("key", 6'h00, 32'h0);
		rdc("ramsz", 6'h04, 32'h22);
		rdc("fwait", 6'h08, 32'h1);
		rdc("ctl0", 6'h0c, 32'h100);
		rdc("strobe", 6'h10, 32'h0);
		rdc("addr", 6'h14, 32'h0);
		rdc("data", 6'h18, 32'h0);
		rdc("flags", 6'h1c, 32'h0);
		rdc("enables", 6'h20, 32'h0);
		chk("eep reset_n", 32'h1, eep.reset_n);
		$display("test reset values done");
	endtask
	task automatic t_protect;
		wrt(6'h04, 32'h0);
		rdc("ramsz locked", 6'h04, 32'h22);
		wrt(6'h00, 32'h96);
		rdc("key", 6'h00, 32'h96);
		wrt(6'h04, 32'hfe01);
		rdc("ramsz", 6'h04, 32'h21);
		wrt(6'h08, 32'h3);
		@(negedge clk);
		chk("ram out", 32'h1, ram);
		chk("wait out", 32'h3, fw);
		wrt(6'h00, 32'h97);
		wrt(6'h08, 32'h0);
		rdc("fwait relocked", 6'h08, 32'h3);
		bus(1'b0, 6'h24, 32'h0);
		chk("unmapped resp", 32'h3, rs);
		chk("unmapped data", 32'h0, q);
		$display("test protection done");
	endtask
	task automatic t_program;
		int n0;
		wrt(6'h00, 32'h96);
		wrt(6'h14, 32'hff);
		wrt(6'h18, 32'ha5);
		wrt(6'h0c, 32'h103);
		@(negedge clk);
		chk("supply", 32'h1, eep.supply_on);
		n0 = pulses;
		wrt(6'h10, 32'h1);
		wrt(6'h10, 32'h1);
		pulse_chk("pulses", n0 + 2);
		chk("pulse addr", 32'hff, p_adr);
		chk("pulse data", 32'ha5, p_dat);
		rdc("strobe", 6'h10, 32'h0);
		repeat (12) @(posedge clk);
		rdc("flags done", 6'h1c, 32'h1);
		wrt(6'h1c, 32'h0);
		rdc("flags w0", 6'h1c, 32'h1);
		chk("irq off", 32'h0, irq);
		wrt(6'h20, 32'h1);
		@(negedge clk);
		chk("irq on", 32'h1, irq);
		wrt(6'h1c, 32'h1);
		rdc("flags w1", 6'h1c, 32'h0);
		chk("irq cleared", 32'h0, irq);
		wrt(6'h0c, 32'h102);
		@(negedge clk);
		chk("supply no mode", 32'h0, eep.supply_on);
		n0 = pulses;
		wrt(6'h10, 32'h1);
		pulse_chk("pulse no mode", n0);
		$display("test programming done");
	endtask
	task automatic t_ecc;
		int n0;
		wrt(6'h1c, 32'h3);
		wrt(6'h20, 32'h3);
		@(negedge clk);
		chk("irq idle", 32'h0, irq);
		ecc_req <= 1'b1;
		repeat (6) @(posedge clk);
		ecc_req <= 1'b0;
		rdc("flags ecc", 6'h1c, 32'h2);
		wrt(6'h20, 32'h3);
		@(negedge clk);
		chk("irq ecc", 32'h1, irq);
		wrt(6'h1c, 32'h2);
		rdc("flags ecc clr", 6'h1c, 32'h0);
		wrt(6'h0c, 32'h001);
		@(negedge clk);
		chk("eep reset_n", 32'h0, eep.reset_n);
		chk("mode in reset", 32'h0, eep.reprogram_mode);
		n0 = pulses;
		wrt(6'h10, 32'h1);
		pulse_chk("pulse in reset", n0);
		ecc_req <= 1'b1;
		repeat (6) @(posedge clk);
		ecc_req <= 1'b0;
		rdc("flags in reset", 6'h1c, 32'h0);
		wrt(6'h0c, 32'h100);
		be <= 4'h2;
		wrt(6'h00, 32'h9600);
		be <= 4'h3;
		rdc("key upper lane", 6'h00, 32'h9696);
		wrt(6'h14, 32'h11);
		rdc("addr relocked", 6'h14, 32'hff);
		wrt(6'h00, 32'h0);
		$display("test ecc and macro reset done");
	endtask
	// events that come and go while the enable is low must leave no trace
	task automatic t_ce;
		ce <= 1'b0;
		ecc_req <= 1'b1;
		repeat (6) @(posedge clk);
		ecc_req <= 1'b0;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		rdc("flags ce low", 6'h1c, 32'h0);
		$display("test clock enable done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 6'h00;
		wd = 32'h0;
		ecc_req = 1'b0;
		ce = 1'b1;
		be = 4'h3;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		pulses = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_protect();
		t_program();
		t_ecc();
		t_ce();
		close_out();
	end
endmodule
`default_nettype wire
